/* cser_pkg.sv */
// Constants shared by the core event router and its chip-level router
package cser_pkg;
  localparam int EVT_N = 128;
  localparam int EVT_W = 7;
  localparam int IRQ_N = 12;
  localparam int SLOT_N = 14;
  localparam int SLOT_W = 5;
  localparam int SLOT_EXC = 12;
  localparam int SLOT_EMU = 13;
  localparam logic [EVT_W-1:0] SEL_RST = 7'h7f;
  localparam int CHIP_N = 32;
  localparam int CHIP_W = 5;
  localparam int ROUT_N = 11;
  localparam int ROUT_W = 4;
  localparam int CPU_CLK_MHZ = 100;
  localparam int DIV_N = 6;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_MAX = 3'(DIV_N - 1);
  localparam int EOI_W = 8;
  localparam logic [EOI_W-1:0] EOI_MEM_PROT = 8'h00;
  localparam int CORE_W = 3;
  localparam int CORE_N = 8;
  localparam int EV_COMB = 0;
  localparam int COMB_N = 4;
  localparam int EV_TRACE = 4;
  localparam int TRACE_N = 5;
  localparam int EV_EMU_DMA = 9;
  localparam int EV_MPF = 10;
  localparam int EV_DBG_RX = 11;
  localparam int EV_DBG_TX = 12;
  localparam int EV_IDMA0 = 13;
  localparam int EV_IDMA1 = 14;
  localparam int EV_SEMERR = 15;
  localparam int EV_SEM = 16;
  localparam int EV_PCIE = 17;
  localparam int EV_TP0ERR = 18;
  localparam int EV_TP1ERR = 19;
  localparam int EV_SRIO = 20;
  localparam int EV_ROUT = 21;
  localparam int EV_QLOW = 32;
  localparam int QLOW_N = 16;
  localparam int EV_QHIGH = 48;
  localparam int QHIGH_N = 4;
  localparam int QHIGH_STRIDE = 8;
  localparam int QHIGH_W = 32;
  localparam int EV_TP = 52;
  localparam int TP_N = 5;
  localparam int EV_OTHER = 57;
  localparam int OTHER_N = 71;
endpackage

/* cser_chip_router.sv */
// Chip-level event router: OR-combining remap with software triggers
`timescale 1ns/100ps
`default_nettype none
module cser_chip_router
  import cser_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic [CHIP_N-1:0] chip_evt,
  input wire logic [CHIP_N-1:0] sw_set,
  input wire logic [CHIP_N-1:0] map_wr,
  input wire logic [ROUT_W-1:0] map_dst,
  input wire logic map_en,
  output logic [ROUT_N-1:0] rout_q
);
  logic [CHIP_N-1:0] en_q;
  logic [ROUT_W-1:0] dst_q [CHIP_N];
  logic [CHIP_N-1:0] pend_q;
  logic [CHIP_N-1:0] pend_d;
  logic [CHIP_N-1:0] act;
  logic [ROUT_N-1:0] rout_d;

  // A trigger landing on a tick survives to the next one
  assign pend_d = (pend_q & ~{CHIP_N{tick}}) | sw_set;
  assign act = chip_evt | pend_q;

  genvar j;
  generate
    for (j = 0; j < ROUT_N; j++) begin : g_out
      logic [CHIP_N-1:0] hit;
      genvar i;
      for (i = 0; i < CHIP_N; i++) begin : g_in
        // One destination per input, many inputs per output
        assign hit[i] = en_q[i] && act[i] &&
                        (dst_q[i] == ROUT_W'(j));
      end
      assign rout_d[j] = |hit;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q <= '0;
      pend_q <= '0;
      rout_q <= '0;
      for (int k = 0; k < CHIP_N; k++) begin
        dst_q[k] <= '0;
      end
    end else if (ce) begin
      pend_q <= pend_d;
      // Only updates at the divided rate
      if (tick) begin
        rout_q <= rout_d;
      end
      for (int k = 0; k < CHIP_N; k++) begin
        if (map_wr[k]) begin
          en_q[k] <= map_en;
          dst_q[k] <= map_dst;
        end
      end
    end
  end

  property p_route_hit;
    @(posedge clk) disable iff (!rst_n)
      (ce && tick && en_q[0] && act[0] && dst_q[0] < ROUT_W'(ROUT_N))
      |=> rout_q[$past(dst_q[0])];
  endproperty
  a_route_hit: assert property (p_route_hit)
    else $error("mapped active input did not reach its output");

  property p_sw_pend;
    @(posedge clk) disable iff (!rst_n)
      (ce && sw_set[0]) |=> pend_q[0];
  endproperty
  a_sw_pend: assert property (p_sw_pend)
    else $error("software trigger lost");
endmodule
`default_nettype wire

/* cser_event_router.sv */
// Per-core event selector with fixed system event map
`timescale 1ns/100ps
`default_nettype none
module cser_event_router
  import cser_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [CORE_W-1:0] core_num,
  input wire logic cfg_we,
  input wire logic [SLOT_W-1:0] cfg_slot,
  input wire logic [EVT_W-1:0] cfg_event,
  input wire logic rmap_we,
  input wire logic [CHIP_W-1:0] rmap_src,
  input wire logic [ROUT_W-1:0] rmap_dst,
  input wire logic rmap_en,
  input wire logic sw_trig_we,
  input wire logic [CHIP_W-1:0] sw_trig_src,
  input wire logic eoi_we,
  input wire logic [EOI_W-1:0] end_of_irq_ack,
  input wire logic [COMB_N-1:0] combiner_out,
  input wire logic trace_buf_half_full_irq,
  input wire logic trace_buf_full_irq,
  input wire logic trace_acq_done_irq,
  input wire logic trace_overflow_irq,
  input wire logic trace_underflow_irq,
  input wire logic emu_dma_irq,
  input wire logic shared_mem_prot_fault,
  input wire logic debug_rx_done_irq,
  input wire logic debug_tx_done_irq,
  input wire logic idma_ch0_irq,
  input wire logic idma_ch1_irq,
  input wire logic sem_err_irq,
  input wire logic sem_irq,
  input wire logic pcie_msg_irq_core,
  input wire logic [CORE_N-1:0] telecom_port0_err_irq,
  input wire logic [CORE_N-1:0] telecom_port1_err_irq,
  input wire logic srio_irq,
  input wire logic [CHIP_N-1:0] chip_events,
  input wire logic [QLOW_N-1:0] queue_low_irq_group0,
  input wire logic [QHIGH_W-1:0] queue_high_irq_core,
  input wire logic telecom0_rx_fsync_irq,
  input wire logic telecom0_rx_superframe_irq,
  input wire logic telecom0_tx_fsync_irq,
  input wire logic telecom0_tx_superframe_irq,
  input wire logic telecom1_rx_fsync_irq,
  input wire logic [OTHER_N-1:0] other_events,
  output logic [IRQ_N-1:0] cpu_maskable_irq_inputs,
  output logic cpu_exception_input,
  output logic emu_event_out,
  output logic mem_prot_level_q
);
  function automatic logic [CHIP_N-1:0] onehot(input logic [CHIP_W-1:0] idx);
    logic [CHIP_N-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic tick;
  logic [EVT_W-1:0] sel_q [SLOT_N];
  logic [SLOT_N-1:0] slot_d;
  logic [SLOT_N-1:0] slot_q;
  logic [CHIP_N-1:0] cfg_dec;
  logic [CHIP_N-1:0] sw_set;
  logic [CHIP_N-1:0] map_wr;
  logic [ROUT_N-1:0] rout;
  logic [EVT_N-1:0] evt_vec;
  logic mem_prot_level_d;
  logic eoi_hit;
  logic [QHIGH_N-1:0] qhigh_sel;
  logic [CHIP_W-1:0] cfg_slot_idx;

  // Divided rate is a one-cycle enable, keeping a single clock domain
  assign tick = ce && (div_q == DIV_MAX);
  assign div_d = (div_q == DIV_MAX) ? '0 : div_q + 3'h1;

  assign sw_set = sw_trig_we ? onehot(sw_trig_src) : '0;
  assign map_wr = rmap_we ? onehot(rmap_src) : '0;
  assign cfg_slot_idx = cfg_slot;
  assign cfg_dec = cfg_we ? onehot(cfg_slot_idx) : '0;

  cser_chip_router u_chip_router (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .chip_evt(chip_events),
    .sw_set(sw_set),
    .map_wr(map_wr),
    .map_dst(rmap_dst),
    .map_en(rmap_en),
    .rout_q(rout)
  );

  // Fault is a pulse; the level stands until software acknowledges it
  assign eoi_hit = eoi_we && (end_of_irq_ack == EOI_MEM_PROT);
  assign mem_prot_level_d = shared_mem_prot_fault ||
                            (mem_prot_level_q && !eoi_hit);

  genvar q;
  generate
    for (q = 0; q < QHIGH_N; q++) begin : g_qhigh
      assign qhigh_sel[q] =
        queue_high_irq_core[q*QHIGH_STRIDE + int'(core_num)];
    end
  endgenerate

  assign evt_vec[EV_COMB +: COMB_N] = combiner_out;
  assign evt_vec[EV_TRACE +: TRACE_N] = {trace_underflow_irq,
                                         trace_overflow_irq,
                                         trace_acq_done_irq,
                                         trace_buf_full_irq,
                                         trace_buf_half_full_irq};
  assign evt_vec[EV_EMU_DMA] = emu_dma_irq;
  assign evt_vec[EV_MPF] = mem_prot_level_q;
  assign evt_vec[EV_DBG_RX] = debug_rx_done_irq;
  assign evt_vec[EV_DBG_TX] = debug_tx_done_irq;
  assign evt_vec[EV_IDMA0] = idma_ch0_irq;
  assign evt_vec[EV_IDMA1] = idma_ch1_irq;
  assign evt_vec[EV_SEMERR] = sem_err_irq;
  assign evt_vec[EV_SEM] = sem_irq;
  assign evt_vec[EV_PCIE] = pcie_msg_irq_core;
  assign evt_vec[EV_TP0ERR] = telecom_port0_err_irq[core_num];
  assign evt_vec[EV_TP1ERR] = telecom_port1_err_irq[core_num];
  assign evt_vec[EV_SRIO] = srio_irq;
  // Chip events reach the selector only through the router
  assign evt_vec[EV_ROUT +: ROUT_N] = rout;
  assign evt_vec[EV_QLOW +: QLOW_N] = queue_low_irq_group0;
  assign evt_vec[EV_QHIGH +: QHIGH_N] = qhigh_sel;
  assign evt_vec[EV_TP +: TP_N] = {telecom1_rx_fsync_irq,
                                   telecom0_tx_superframe_irq,
                                   telecom0_tx_fsync_irq,
                                   telecom0_rx_superframe_irq,
                                   telecom0_rx_fsync_irq};
  assign evt_vec[EV_OTHER +: OTHER_N] = other_events;

  genvar s;
  generate
    for (s = 0; s < SLOT_N; s++) begin : g_slot
      // Any of the 128 events may feed any slot
      assign slot_d[s] = evt_vec[sel_q[s]];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= '0;
      mem_prot_level_q <= 1'b0;
      slot_q <= '0;
      for (int k = 0; k < SLOT_N; k++) begin
        sel_q[k] <= SEL_RST;
      end
    end else if (ce) begin
      div_q <= div_d;
      mem_prot_level_q <= mem_prot_level_d;
      slot_q <= slot_d;
      // Slot numbers above the emulation slot are ignored
      for (int k = 0; k < SLOT_N; k++) begin
        if (cfg_dec[k]) begin
          sel_q[k] <= cfg_event;
        end
      end
    end
  end

  assign cpu_maskable_irq_inputs = slot_q[IRQ_N-1:0];
  assign cpu_exception_input = slot_q[SLOT_EXC];
  assign emu_event_out = slot_q[SLOT_EMU];

  logic slot0_evt;
  assign slot0_evt = evt_vec[sel_q[0]];

  property p_sel_follow;
    @(posedge clk) disable iff (!rst_n)
      (ce && !cfg_we) ##1 ce |-> cpu_maskable_irq_inputs[0] ==
                                 $past(slot0_evt, 1);
  endproperty
  a_sel_follow: assert property (p_sel_follow)
    else $error("irq slot 0 does not follow its selected event");

  property p_div_tick;
    @(posedge clk) disable iff (!rst_n)
      tick |=> (div_q == '0);
  endproperty
  a_div_tick: assert property (p_div_tick)
    else $error("divider did not wrap after tick");

  property p_div_range;
    @(posedge clk) disable iff (!rst_n)
      div_q <= DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("divider out of range");

  sequence s_fault;
    ce && shared_mem_prot_fault;
  endsequence

  property p_mp_set;
    @(posedge clk) disable iff (!rst_n)
      s_fault |=> mem_prot_level_q;
  endproperty
  a_mp_set: assert property (p_mp_set)
    else $error("protection fault did not raise level");

  property p_mp_clear;
    @(posedge clk) disable iff (!rst_n)
      (ce && mem_prot_level_q && !shared_mem_prot_fault && eoi_hit)
      |=> !mem_prot_level_q;
  endproperty
  a_mp_clear: assert property (p_mp_clear)
    else $error("end-of-irq code 0 did not clear level");

  property p_comb_map;
    @(posedge clk) disable iff (!rst_n)
      evt_vec[EV_COMB +: COMB_N] == combiner_out;
  endproperty
  a_comb_map: assert property (p_comb_map)
    else $error("combiner outputs not on events 0 to 3");

  property p_qhigh_map;
    @(posedge clk) disable iff (!rst_n)
      evt_vec[EV_QHIGH] == queue_high_irq_core[core_num];
  endproperty
  a_qhigh_map: assert property (p_qhigh_map)
    else $error("event 48 not high queue of this core");

  // Clock enable low holds every output where it stands
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(slot_q) && $stable(mem_prot_level_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while clock enable low");

  property p_cfg_take;
    @(posedge clk) disable iff (!rst_n)
      (ce && cfg_we && cfg_slot == SLOT_W'(SLOT_EXC))
      |=> sel_q[SLOT_EXC] == $past(cfg_event);
  endproperty
  a_cfg_take: assert property (p_cfg_take)
    else $error("exception slot selector not written");

  property p_exc_follow;
    @(posedge clk) disable iff (!rst_n)
      ce |=> cpu_exception_input == $past(evt_vec[sel_q[SLOT_EXC]]);
  endproperty
  a_exc_follow: assert property (p_exc_follow)
    else $error("exception input does not follow its event");

  property p_emu_follow;
    @(posedge clk) disable iff (!rst_n)
      ce |=> emu_event_out == $past(evt_vec[sel_q[SLOT_EMU]]);
  endproperty
  a_emu_follow: assert property (p_emu_follow)
    else $error("emulation output does not follow its event");

  // Only a code-0 write may drop the level; other codes are ignored
  property p_mp_hold;
    @(posedge clk) disable iff (!rst_n)
      (ce && mem_prot_level_q && (!eoi_we || end_of_irq_ack != EOI_MEM_PROT))
      |=> mem_prot_level_q;
  endproperty
  a_mp_hold: assert property (p_mp_hold)
    else $error("protection level dropped without code 0");

  // Six enabled cycles from one tick to the next, none in between
  sequence s_tick_run;
    tick ##1 ce [*6];
  endsequence

  property p_tick_period;
    @(posedge clk) disable iff (!rst_n)
      s_tick_run |-> tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("router tick not one in six enabled cycles");

  property p_tick_gap;
    @(posedge clk) disable iff (!rst_n)
      tick |=> (!tick) [*5];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("router tick came too early");
endmodule
`default_nettype wire

/* cser_cpu_model.sv */
// CPU-side model: sees the level flag and answers with end-of-irq writes
`timescale 1ns/100ps
`default_nettype none
module cser_cpu_model
  import cser_pkg::*;
(
  input wire logic clk,
  input wire logic level,
  input wire logic req,
  input wire logic [EOI_W-1:0] code,
  output logic eoi_we = 1'b0,
  output logic [EOI_W-1:0] end_of_irq_ack = '1
);
  // Acks only a standing level; idle code is inverted, never left stale
  always @(posedge clk) begin
    eoi_we <= #1 level && req;
    end_of_irq_ack <= #1 (level && req) ? code : ~code;
  end
endmodule
`default_nettype wire

/* tb_cser_event_router.sv */
// Self-checking bench for the per-core event router
`timescale 1ns/100ps
`default_nettype none
module tb_cser_event_router;
  import cser_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, cfg_we = 0, rmap_we = 0, rmap_en = 0;
  logic sw_trig_we = 0, fault = 0, req = 0, mp = 0, exc, emu, mpl, eoi_we;
  logic [EOI_W-1:0] code = '0, end_of_irq_ack;
  logic [SLOT_W-1:0] cfg_slot = '0;
  logic [EVT_W-1:0] cfg_event = '0;
  logic [CHIP_W-1:0] rmap_src = '0, sw_trig_src = '0;
  logic [ROUT_W-1:0] rmap_dst = '0;
  logic [CORE_W-1:0] core_num = '0;
  logic [CHIP_N-1:0] chip_events = '0;
  logic [ROUT_N-1:0] rt = '0;
  logic [IRQ_N-1:0] irq;
  logic [255:0] r = '0;
  logic [127:0] ev;
  logic [15:0] hold;
  logic [31:0] seed = 32'h795d;
  int sel[SLOT_N];
  int error_cnt = 0, n_checks = 0, cyc = 0, cnt;
  // Per-core picks follow core_num; router outputs come from the model rt
  assign ev = {r[127:52], r[168+core_num], r[160+core_num],
    r[152+core_num], r[144+core_num], r[47:32], rt, r[20],
    r[136+core_num], r[128+core_num], r[17:11], mp, r[9:0]};
  cser_event_router cser_event_router_i (
    .clk, .rst_n, .ce, .core_num, .cfg_we, .cfg_slot, .cfg_event,
    .rmap_we, .rmap_src, .rmap_dst, .rmap_en, .sw_trig_we, .sw_trig_src,
    .eoi_we, .end_of_irq_ack, .combiner_out(r[3:0]),
    .trace_buf_half_full_irq(r[4]), .trace_buf_full_irq(r[5]),
    .trace_acq_done_irq(r[6]), .trace_overflow_irq(r[7]),
    .trace_underflow_irq(r[8]), .emu_dma_irq(r[9]),
    .shared_mem_prot_fault(fault), .debug_rx_done_irq(r[11]),
    .debug_tx_done_irq(r[12]), .idma_ch0_irq(r[13]), .idma_ch1_irq(r[14]),
    .sem_err_irq(r[15]), .sem_irq(r[16]), .pcie_msg_irq_core(r[17]),
    .telecom_port0_err_irq(r[135:128]), .telecom_port1_err_irq(r[143:136]),
    .srio_irq(r[20]), .chip_events, .queue_low_irq_group0(r[47:32]),
    .queue_high_irq_core(r[175:144]), .telecom0_rx_fsync_irq(r[52]),
    .telecom0_rx_superframe_irq(r[53]), .telecom0_tx_fsync_irq(r[54]),
    .telecom0_tx_superframe_irq(r[55]), .telecom1_rx_fsync_irq(r[56]),
    .other_events(r[127:57]), .cpu_maskable_irq_inputs(irq),
    .cpu_exception_input(exc), .emu_event_out(emu), .mem_prot_level_q(mpl)
  );
  cser_cpu_model cser_cpu_model_i (
    .clk, .level(mpl), .req, .code, .eoi_we, .end_of_irq_ack
  );
  initial begin
    forever #5 clk = ~clk;
  end
  // Ceiling well above the roughly 800 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      stop_test();
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] expv();
    logic [15:0] e;
    e = '0;
    for (int s = 0; s < SLOT_N; s++) e[s] = ev[sel[s]];
    return e;
  endfunction
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rnd();
    for (int i = 0; i < 8; i++) r[i*32+:32] = xs();
    core_num = CORE_W'(xs());
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task cfg(int s, int e);
    cfg_slot = SLOT_W'(s);
    cfg_event = EVT_W'(e);
    cfg_we = 1;
    step(1);
    cfg_we = 0;
    if (s < SLOT_N) sel[s] = e;
    step(1);
  endtask
  task rmap(int s, int d, bit en = 1);
    rmap_src = CHIP_W'(s);
    rmap_dst = ROUT_W'(d);
    rmap_en = en;
    rmap_we = 1;
    step(1);
    rmap_we = 0;
    step(1);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    foreach (sel[s]) sel[s] = 127;
    step(16);
    rst_n = 1;
    chk("reset outs", 16'h0, {mpl, emu, exc, irq});
    $display("reset test done");
    // Every event number through a slot; slots 14, 15 must be ignored
    for (int e = 0; e < EVT_N; e++) begin
      rnd();
      cfg(e % 16, e);
      // Slots 14 and 15 are refused, so carry those events via 12 and 13
      if (e % 16 >= SLOT_N) cfg(e % 16 - 2, e);
      step(3);
      chk("slots", expv(), {emu, exc, irq});
      if (e % 32 == 31) begin
        hold = expv();
        ce = 0;
        rnd();
        step(3);
        chk("frozen", hold, {emu, exc, irq});
        ce = 1;
      end
    end
    $display("event map test done");
    cfg(0, EV_MPF);
    fault = 1;
    step(1);
    fault = 0;
    mp = 1;
    step(2);
    chk("fault", {mp, 14'(expv())}, {mpl, emu, exc, irq});
    code = 8'h5a;
    req = 1;
    step(1);
    req = 0;
    step(3);
    chk("bad ack", 1, mpl);
    code = EOI_MEM_PROT;
    req = 1;
    step(1);
    req = 0;
    mp = 0;
    step(3);
    chk("ack", {mp, 14'(expv())}, {mpl, emu, exc, irq});
    $display("end-of-irq test done");
    cfg(1, EV_ROUT + 3);
    cfg(2, EV_ROUT + 5);
    rmap(7, 3);
    rmap(9, 3);
    chip_events[9] = 1;
    rt[3] = 1;
    step(10);
    chk("or 9", expv(), {emu, exc, irq});
    chip_events = 32'h80;
    step(10);
    chk("or 7", expv(), {emu, exc, irq});
    rmap(7, 5);
    rt = 11'h20;
    step(10);
    chk("remap", expv(), {emu, exc, irq});
    chip_events = '0;
    rt = '0;
    step(10);
    rmap(0, 3);
    sw_trig_src = 5'h00;
    sw_trig_we = 1;
    step(1);
    sw_trig_we = 0;
    cnt = 0;
    repeat (20) begin
      step(1);
      cnt += irq[1];
    end
    chk("sw width", DIV_N, cnt);
    rmap(9, 3, 0);
    chip_events[9] = 1;
    step(10);
    chk("disabled", expv(), {emu, exc, irq});
    $display("chip router test done");
    chip_events = '0;
    rnd();
    r[127] = 1'b1;
    rst_n = 0;
    step(2);
    rst_n = 1;
    foreach (sel[s]) sel[s] = 127;
    chk("mid reset", 16'h0, {mpl, emu, exc, irq});
    step(3);
    chk("sel reset", expv(), {emu, exc, irq});
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
